/* File: verilog/ocs_cfg.svh */
// Purpose: constants for the operating-state controller
// Assumes: included by bare name in the controller and sequencer modules, not in the package
// Notes:   byte offsets on the Avalon-MM register port
`ifndef OCS_CFG_SVH
`define OCS_CFG_SVH
// register byte offsets
`define OCS_OFS_CMD      4'h0
`define OCS_OFS_CFG      4'h4
`define OCS_OFS_STATUS   4'h8
`define OCS_OFS_DSW      4'hC
// command register bits (write, self clearing)
`define OCS_CMD_HALT     0
`define OCS_CMD_WARM     1
`define OCS_CMD_COLD     2
// configuration register bits
`define OCS_CFG_REMOTE   0
`define OCS_CFG_STHALT   1
`define OCS_CFG_RECCOLD  2
`define OCS_CFG_W        3
`define OCS_CFG_RST      3'h0
// mode selector positions
`define OCS_SEL_HALT     2'h1
`define OCS_SEL_RUN      2'h2
`define OCS_SEL_RUNCLR   2'h3
// reported operating state codes
`define OCS_CODE_NR      2'h0
`define OCS_CODE_READY   2'h1
`define OCS_CODE_RUN     2'h2
// diagnostic status word bits
`define OCS_DSW_HWERR    0
`define OCS_DSW_PRGERR   1
`define OCS_DSW_NOPROG   2
`define OCS_DSW_TAB      3
// status register fields
`define OCS_STS_CODE     1:0
`define OCS_STS_NEEDCOLD 2
`define OCS_STS_BUSY     3
`define OCS_STS_FINISH   4
`endif

/* File: verilog/ocs_pkg.sv */
// Purpose: types shared by the operating-state controller
// Assumes: ocs_cfg.svh holds the numbers
// Notes:   state codes are Gray along not ready, ready, start, run
package ocs_pkg;
  typedef enum logic [1:0] {
    OCS_NOTREADY = 2'h0,
    OCS_READY    = 2'h1,
    OCS_START    = 2'h3,
    OCS_RUN      = 2'h2
  } ocs_state_type;

  typedef enum logic [1:0] {
    OCS_MIDLE = 2'h0,
    OCS_MCOPY = 2'h1,
    OCS_MUPD  = 2'h3
  } ocs_mstate_type;

  // Avalon-MM request from the bus master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } ocs_avreq_type;

  // operator, power and fault events (synchronous to clk_sys)
  typedef struct packed {
    logic resetBtn;
    logic powerOn;
    logic cycleDone;
    logic hwError;
    logic progError;
    logic progLoaded;
    logic tabPulled;
    logic slaveMode;
    logic masterHalt;
    logic progXfer;
    logic moduleBoot;
  } ocs_evt_type;

  // program memory status from the memory module path
  typedef struct packed {
    logic progMatch;
    logic backupValid;
    logic ramValid;
    logic xferDone;
  } ocs_mem_type;
endpackage

/* File: verilog/ocs_prog_mgr.sv */
// Purpose: compare, restore and refresh of the backup program
// Assumes: one start pulse at a time; xferDone ends any copy
// Notes:   a forced refresh of the module wins over restoring RAM
`timescale 1ns/1ps
`default_nettype none
`include "ocs_cfg.svh"
module ocs_prog_mgr (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic                clkEn,
  // control
  input  wire logic                start,
  input  wire logic                forceUpd,
  input  wire ocs_pkg::ocs_mem_type mem,
  // results
  output logic                     copyToRam,
  output logic                     copyToMod,
  output logic                     done
);
  typedef struct packed {
    ocs_pkg::ocs_mstate_type st;
    logic                    copyToRam;
    logic                    copyToMod;
    logic                    done;
  } ocs_mgr_type;

  ocs_mgr_type s_r;
  ocs_mgr_type s_nxt;

  // next-state logic of the copy sequencer
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      ocs_pkg::OCS_MIDLE: begin
        if (start) begin
          if (!mem.progMatch && mem.backupValid && !forceUpd) begin
            s_nxt.st = ocs_pkg::OCS_MCOPY;
            s_nxt.copyToRam = 1'b1;
          end else if (mem.ramValid && (forceUpd || !mem.backupValid)) begin
            s_nxt.st = ocs_pkg::OCS_MUPD;
            s_nxt.copyToMod = 1'b1;
          end else begin
            s_nxt.done = 1'b1;
          end
        end
      end
      ocs_pkg::OCS_MCOPY,
      ocs_pkg::OCS_MUPD: begin
        if (mem.xferDone) begin
          s_nxt.st = ocs_pkg::OCS_MIDLE;
          s_nxt.copyToRam = 1'b0;
          s_nxt.copyToMod = 1'b0;
          s_nxt.done = 1'b1;
        end
      end
      default: begin
        s_nxt.st = ocs_pkg::OCS_MIDLE;
        s_nxt.copyToRam = 1'b0;
        s_nxt.copyToMod = 1'b0;
      end
    endcase
  end

  // state register; clock enable freezes it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{st: ocs_pkg::OCS_MIDLE, default: 1'b0};
    end else if (clkEn) begin
      s_r <= s_nxt;
    end
  end

  assign copyToRam = s_r.copyToRam;
  assign copyToMod = s_r.copyToMod;
  assign done      = s_r.done;
endmodule
`default_nettype wire

/* File: verilog/ocs_state_machine.sv */
// Purpose: operating-state controller of a controller CPU
// Assumes: all inputs synchronous to clk_sys; events are one-cycle pulses
// Notes:   registers on Avalon-MM, one wait cycle per access
// How it works
// - exactly one of run, ready, not ready
// - ready: program held, outputs cleared, disabled
// - halt position: reset or power-on gives ready
// - remote slave follows master halt into ready
// - pulling module tab forces ready
// - run positions: reset or power-on gives run
// - register port answers in every state
// - missing program or errors force not ready
// - fault gone: reset, power, command leave
// - reset acknowledges diagnostic status word; here only from run outside halt, or from ready or not ready in halt
// - halt power cycle: finish cycle, keep not-ready
// - run position from not ready via ready
// - run power cycle: finish cycle, resume
// - position 3 power-on or reset: cold start
// - every start compares backup, restores RAM
// - new program, halt start condition: not ready
// - refresh defective module; refresh on transfer
// - cold start clears data, restarts program
// - cold start from ready, not ready; from run only by power-on in position 3
// - run position recovery may be cold start
// - new program needs cold start, no warm
// - run executes cyclically, not ready never
//
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "ocs_cfg.svh"
module ocs_state_machine #(
  parameter int DSW_W = 8
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rstn,
  input  wire logic                  clkEn,
  // operator controls and events
  input  wire logic [1:0]            modeSel,
  input  wire ocs_pkg::ocs_evt_type  evt,
  input  wire ocs_pkg::ocs_mem_type  mem,
  // Avalon-MM slave
  input  wire ocs_pkg::ocs_avreq_type avReq,
  output logic [31:0]                readdata,
  output logic                       waitrequest,
  // controller outputs
  output logic [1:0]                 stateCode,
  output logic                       execEnable,
  output logic                       outputsEnable,
  output logic                       clearData,
  output logic                       restartTop,
  output logic                       copyToRam,
  output logic                       copyToMod,
  output logic [DSW_W-1:0]           dswWord
);
  initial begin
    if (DSW_W < 4 || DSW_W > 32) begin
      $error("DSW_W must lie between 4 and 32");
    end
  end

  typedef struct packed {
    ocs_pkg::ocs_state_type st;
    logic                   runTgt;     // start ends in run
    logic                   coldReq;    // start is a cold start
    logic                   needCold;   // new program not yet cold started
    logic                   newProg;    // program came by transfer or boot
    logic                   finishPend; // power cycle waits for cycle end
    logic                   finishRun;  // after finishing, resume run
    logic [DSW_W-1:0]       diagnostic_status_word;
    logic [`OCS_CFG_W-1:0]  cfg;
    logic [2:0]             cmd;
    logic                   waitR;
    logic [31:0]            rdata;
    logic [1:0]             code;
    logic                   execEn;
    logic                   outEn;
    logic                   clearData;
    logic                   restartTop;
    logic                   mgrStart;
    logic                   mgrForce;
    logic                   prevTab;
    logic                   prevMhalt;
  } ocs_top_type;

  ocs_top_type s_r;
  ocs_top_type s_nxt;
  logic        mgrDone;

  // backup program compare and refresh sequencer
  ocs_prog_mgr u_prog_mgr (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .clkEn     (clkEn),
    .start     (s_r.mgrStart),
    .forceUpd  (s_r.mgrForce),
    .mem       (mem),
    .copyToRam (copyToRam),
    .copyToMod (copyToMod),
    .done      (mgrDone)
  );

  logic fault;
  logic tabEdge;
  logic mhaltEdge;
  logic busOk;
  logic isHalt;
  logic isRun;
  logic isClr;
  logic idleSt;

  // level faults are checked every cycle so they cannot be missed
  assign fault = evt.hwError | evt.progError | ~evt.progLoaded;
  assign tabEdge = evt.tabPulled & ~s_r.prevTab;
  assign mhaltEdge = evt.masterHalt & ~s_r.prevMhalt;
  assign busOk = (avReq.read | avReq.write) & ~s_r.waitR;
  assign isHalt = (modeSel == `OCS_SEL_HALT);
  assign isRun = (modeSel == `OCS_SEL_RUN);
  assign isClr = (modeSel == `OCS_SEL_RUNCLR);
  assign idleSt = (s_r.st == ocs_pkg::OCS_READY) ||
                  (s_r.st == ocs_pkg::OCS_NOTREADY);

  // one combinational process computes every next value
  always_comb begin
    logic goReady;
    logic goStart;
    logic stRun;
    logic stCold;
    logic ack;
    goReady = 1'b0;
    goStart = 1'b0;
    stRun = 1'b0;
    stCold = 1'b0;
    ack = 1'b0;
    s_nxt = s_r;
    s_nxt.clearData = 1'b0;
    s_nxt.restartTop = 1'b0;
    s_nxt.mgrStart = 1'b0;
    s_nxt.mgrForce = 1'b0;
    s_nxt.cmd = 3'h0;
    s_nxt.prevTab = evt.tabPulled;
    s_nxt.prevMhalt = evt.masterHalt;

    // reset button, by selector position and present state
    if (evt.resetBtn) begin
      if (isHalt) begin
        goReady = 1'b1;
        ack = idleSt;
      end else if (s_r.st == ocs_pkg::OCS_RUN) begin
        ack = 1'b1;
      end else if (idleSt) begin
        goStart = 1'b1;
        stRun = 1'b1;
        stCold = isClr | (s_r.st == ocs_pkg::OCS_NOTREADY &&
                 s_r.cfg[`OCS_CFG_RECCOLD]);
      end
    end

    // power-on: outside position 3 a running cycle is first finished
    if (evt.powerOn) begin
      if (isClr) begin
        goStart = 1'b1;
        stRun = 1'b1;
        stCold = 1'b1;
      end else if (s_r.st == ocs_pkg::OCS_RUN) begin
        s_nxt.finishPend = 1'b1;
        s_nxt.finishRun = isRun;
      end else if (s_r.st == ocs_pkg::OCS_READY) begin
        goStart = 1'b1;
        stRun = isRun;
      end else if (s_r.st == ocs_pkg::OCS_NOTREADY && isRun) begin
        goStart = 1'b1;
        stRun = 1'b1;
        stCold = s_r.cfg[`OCS_CFG_RECCOLD];
      end
    end

    // interrupted cycle done: resume run or fall to ready
    if (s_r.finishPend && evt.cycleDone) begin
      s_nxt.finishPend = 1'b0;
      goStart = 1'b1;
      stRun = s_r.finishRun;
    end

    // commands from the programming PC
    if (s_r.cmd[`OCS_CMD_HALT]) begin
      goReady = 1'b1;
    end
    if (s_r.cmd[`OCS_CMD_WARM] && idleSt) begin
      goStart = 1'b1;
      stRun = 1'b1;
    end
    if (s_r.cmd[`OCS_CMD_COLD] && idleSt) begin
      goStart = 1'b1;
      stRun = 1'b1;
      stCold = 1'b1;
    end

    // remote halt and module removal
    if (mhaltEdge && evt.slaveMode && s_r.cfg[`OCS_CFG_REMOTE]) begin
      goReady = 1'b1;
    end
    if (tabEdge) begin
      goReady = 1'b1;
    end

    // a new program forces a cold start; only a transfer also refreshes the module
    if (evt.progXfer || evt.moduleBoot) begin
      s_nxt.needCold = 1'b1;
      s_nxt.newProg = 1'b1;
    end
    if (evt.progXfer) begin
      s_nxt.mgrStart = 1'b1;
      s_nxt.mgrForce = 1'b1;
    end

    // state transitions; removal wins over starts
    case (s_r.st)
      ocs_pkg::OCS_START: begin
        if (mgrDone && !s_r.mgrStart) begin
          if (s_r.runTgt && s_r.coldReq) begin
            s_nxt.st = ocs_pkg::OCS_RUN;
            s_nxt.clearData = 1'b1;
            s_nxt.restartTop = 1'b1;
            // a program arriving in this very cycle still needs one
            s_nxt.needCold = evt.progXfer | evt.moduleBoot;
            s_nxt.newProg = evt.progXfer | evt.moduleBoot;
          end else if (s_r.runTgt && s_r.needCold) begin
            // warm resumption of a fresh program is refused
            s_nxt.st = (s_r.newProg && s_r.cfg[`OCS_CFG_STHALT]) ?
                       ocs_pkg::OCS_NOTREADY :
                       ocs_pkg::OCS_READY;
          end else if (s_r.runTgt) begin
            s_nxt.st = ocs_pkg::OCS_RUN;
          end else begin
            s_nxt.st = ocs_pkg::OCS_READY;
          end
        end
      end
      ocs_pkg::OCS_NOTREADY,
      ocs_pkg::OCS_READY,
      ocs_pkg::OCS_RUN: begin
        if (goReady) begin
          s_nxt.st = ocs_pkg::OCS_READY;
          s_nxt.finishPend = 1'b0;
        end else if (goStart) begin
          s_nxt.st = ocs_pkg::OCS_START;
          s_nxt.runTgt = stRun;
          s_nxt.coldReq = stCold;
          s_nxt.mgrStart = 1'b1;
          s_nxt.mgrForce = 1'b0;
        end
      end
      default: begin
        s_nxt.st = ocs_pkg::OCS_NOTREADY;
      end
    endcase

    // errors override any other transition of this cycle
    if (fault) begin
      s_nxt.st = ocs_pkg::OCS_NOTREADY;
      s_nxt.finishPend = 1'b0;
    end

    // diagnostic word: acknowledge clears, a new event still sets
    if (ack) begin
      s_nxt.diagnostic_status_word = '0;
    end
    if (busOk && avReq.write && avReq.address == `OCS_OFS_DSW) begin
      s_nxt.diagnostic_status_word = s_nxt.diagnostic_status_word & ~avReq.writedata[DSW_W-1:0];
    end
    if (evt.hwError) begin
      s_nxt.diagnostic_status_word[`OCS_DSW_HWERR] = 1'b1;
    end
    if (evt.progError) begin
      s_nxt.diagnostic_status_word[`OCS_DSW_PRGERR] = 1'b1;
    end
    if (!evt.progLoaded) begin
      s_nxt.diagnostic_status_word[`OCS_DSW_NOPROG] = 1'b1;
    end
    if (tabEdge) begin
      s_nxt.diagnostic_status_word[`OCS_DSW_TAB] = 1'b1;
    end

    // bus slave: one wait cycle, served regardless of state
    s_nxt.waitR = 1'b1;
    if ((avReq.read || avReq.write) && s_r.waitR) begin
      s_nxt.waitR = 1'b0;
    end
    if ((avReq.read || avReq.write) && s_r.waitR) begin
      case (avReq.address)
        `OCS_OFS_CFG: begin
          s_nxt.rdata = {{(32-`OCS_CFG_W){1'b0}}, s_r.cfg};
        end
        `OCS_OFS_STATUS: begin
          s_nxt.rdata = 32'h0;
          s_nxt.rdata[`OCS_STS_CODE] = s_r.code;
          s_nxt.rdata[`OCS_STS_NEEDCOLD] = s_r.needCold;
          s_nxt.rdata[`OCS_STS_BUSY] = (s_r.st == ocs_pkg::OCS_START);
          s_nxt.rdata[`OCS_STS_FINISH] = s_r.finishPend;
        end
        `OCS_OFS_DSW: begin
          s_nxt.rdata = 32'h0;
          s_nxt.rdata[DSW_W-1:0] = s_r.diagnostic_status_word;
        end
        default: begin
          s_nxt.rdata = 32'h0; // command and unmapped read zero
        end
      endcase
    end
    if (busOk && avReq.write) begin
      if (avReq.address == `OCS_OFS_CMD) begin
        s_nxt.cmd = avReq.writedata[2:0];
      end
      if (avReq.address == `OCS_OFS_CFG) begin
        s_nxt.cfg = avReq.writedata[`OCS_CFG_W-1:0];
      end
    end

    // outputs follow the next state; start reports as ready
    case (s_nxt.st)
      ocs_pkg::OCS_RUN: begin
        s_nxt.code = `OCS_CODE_RUN;
        s_nxt.execEn = 1'b1;
        s_nxt.outEn = 1'b1;
      end
      ocs_pkg::OCS_READY,
      ocs_pkg::OCS_START: begin
        s_nxt.code = `OCS_CODE_READY;
        s_nxt.execEn = 1'b0;
        s_nxt.outEn = 1'b0;
      end
      default: begin
        s_nxt.code = `OCS_CODE_NR;
        s_nxt.execEn = 1'b0;
        s_nxt.outEn = 1'b0;
      end
    endcase
  end

  // single state register; clock enable freezes everything
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{st: ocs_pkg::OCS_NOTREADY, cfg: `OCS_CFG_RST,
               waitR: 1'b1, code: `OCS_CODE_NR, default: '0};
    end else if (clkEn) begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign readdata      = s_r.rdata;
  assign waitrequest   = s_r.waitR;
  assign stateCode     = s_r.code;
  assign execEnable    = s_r.execEn;
  assign outputsEnable = s_r.outEn;
  assign clearData     = s_r.clearData;
  assign restartTop    = s_r.restartTop;
  assign dswWord       = s_r.diagnostic_status_word;
endmodule
`default_nettype wire

/* File: testbench/ocs_sm_asserts.sv */
// Purpose: port checks for ocs_state_machine
// Assumes: one clock domain, reset active low
// Notes:   attached by bind below the module
`timescale 1ns/1ps
`default_nettype none
module ocs_sm_asserts #(
  parameter int DSW_W = 8
) (
  // clock and reset
  input wire logic                   clk_sys,
  input wire logic                   rstn,
  input wire logic                   clkEn,
  // stimulus
  input wire logic [1:0]             modeSel,
  input wire ocs_pkg::ocs_evt_type   evt,
  input wire ocs_pkg::ocs_mem_type   mem,
  input wire ocs_pkg::ocs_avreq_type avReq,
  // results
  input wire logic [31:0]            readdata,
  input wire logic                   waitrequest,
  input wire logic [1:0]             stateCode,
  input wire logic                   execEnable,
  input wire logic                   outputsEnable,
  input wire logic                   clearData,
  input wire logic                   restartTop,
  input wire logic                   copyToRam,
  input wire logic                   copyToMod,
  input wire logic [DSW_W-1:0]       dswWord
);
  logic fault;
  // any fault source; a missing program counts as one
  assign fault = evt.hwError | evt.progError | !evt.progLoaded;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  chk_code_legal: assert property (stateCode != 2'h3)
    else $error("illegal state code");
  chk_ready_quiet: assert property (stateCode == 2'h1 |->
    !execEnable && !outputsEnable) else $error("ready but enabled");
  chk_exec_run: assert property (execEnable == (stateCode == 2'h2)
    && outputsEnable == execEnable) else $error("exec not tied to run");
  chk_fault_wins: assert property (clkEn && fault |=>
    stateCode == 2'h0) else $error("fault did not give not ready");
  chk_bus_answer: assert property (clkEn && (avReq.read || avReq.write)
    && waitrequest |=> !waitrequest) else $error("no bus answer");
  chk_wait_pulse: assert property (clkEn && !waitrequest |=>
    waitrequest) else $error("waitrequest low too long");
  chk_tab_ready: assert property (clkEn && $rose(evt.tabPulled)
    && !fault && stateCode == 2'h2 && !evt.resetBtn && !evt.powerOn
    |=> stateCode == 2'h1) else $error("tab pull kept run");
  chk_run_reset: assert property (clkEn && evt.resetBtn
    && stateCode == 2'h2 && modeSel[1] && !fault && !evt.powerOn
    && !$rose(evt.tabPulled) && !$rose(evt.masterHalt)
    |=> stateCode == 2'h2) else $error("reset left run");
  chk_halt_ready: assert property (clkEn && evt.resetBtn
    && modeSel == 2'h1 && stateCode != 2'h1 && !fault && !evt.powerOn
    |=> stateCode == 2'h1) else $error("halt reset not ready");
  chk_cold_pulse: assert property (clearData |-> restartTop
    && stateCode == 2'h2 ##1 !clearData) else $error("bad cold pulse");
  chk_copy_end: assert property (clkEn && copyToRam && mem.xferDone
    |=> !copyToRam) else $error("copy outlived done");
  cov_cold: cover property (clearData);
  cov_copy: cover property ($rose(copyToRam));
  cov_tab: cover property ($rose(evt.tabPulled) && stateCode == 2'h2);
endmodule
bind ocs_state_machine ocs_sm_asserts #(.DSW_W(DSW_W)) i_chk (.*);
`default_nettype wire

/* File: testbench/ocs_mem_model.sv */
// Purpose: memory module path facing the controller
// Assumes: bench pulses mismatch for one cycle
// Notes:   each copy ends with one xferDone pulse after lat+1 cycles
`timescale 1ns/1ps
`default_nettype none
module ocs_mem_model (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rstn,
  // bench controls
  input  wire logic          mismatch,
  input  wire logic [3:0]    lat,
  // copy requests
  input  wire logic          copyToRam,
  input  wire logic          copyToMod,
  // status back
  output var ocs_pkg::ocs_mem_type mem
);
  logic [3:0] cnt;
  logic       diff;
  // slow answers stretch the start; the restore clears the difference
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt <= 4'h0;
      diff <= 1'b0;
      mem <= '0;
    end else begin
      mem.backupValid <= 1'b1;
      mem.ramValid <= 1'b1;
      mem.progMatch <= !(diff || mismatch);
      mem.xferDone <= 1'b0;
      if (mismatch) diff <= 1'b1;
      if ((copyToRam || copyToMod) && !mem.xferDone) begin
        cnt <= cnt + 4'h1;
        if (cnt >= lat) begin
          mem.xferDone <= 1'b1;
          cnt <= 4'h0;
          diff <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// Purpose: self-checking bench for ocs_state_machine
// Assumes: 100 MHz clk_sys, reset low for 5 cycles
// Notes:   an integer model predicts the state after each event
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int RST = 10, POW = 9, CYC = 8, HWE = 7, TAB = 4;
  localparam int SLV = 3, MH = 2, XFR = 1;
  logic                   clk_sys = 1'b0;
  logic                   rstn = 1'b0;
  logic                   clkEn = 1'b1;
  logic [1:0]             modeSel = 2'h1;
  ocs_pkg::ocs_evt_type   evt = 11'h020;
  ocs_pkg::ocs_avreq_type avReq = '0;
  ocs_pkg::ocs_mem_type   mem;
  logic [31:0]            readdata, q;
  logic                   waitrequest, execEnable, outputsEnable;
  logic                   clearData, restartTop, copyToRam, copyToMod;
  logic                   mm = 1'b0, cpPrev = 1'b0;
  logic [1:0]             stateCode;
  logic [7:0]             dswWord;
  logic [3:0]             lat = 4'h1;
  int error_cnt = 0, n_checks = 0, nCold = 0, nCopy = 0;
  int seed = 32'h8d115567;
  int e, c0, p0, r;
  ocs_state_machine #(.DSW_W(8)) i_dut (.clk_sys(clk_sys), .rstn(rstn),
    .clkEn(clkEn), .modeSel(modeSel), .evt(evt), .mem(mem),
    .avReq(avReq), .readdata(readdata), .waitrequest(waitrequest),
    .stateCode(stateCode), .execEnable(execEnable),
    .outputsEnable(outputsEnable), .clearData(clearData),
    .restartTop(restartTop), .copyToRam(copyToRam),
    .copyToMod(copyToMod), .dswWord(dswWord));
  ocs_mem_model i_mem (.clk_sys(clk_sys), .rstn(rstn), .mismatch(mm),
    .lat(lat), .copyToRam(copyToRam), .copyToMod(copyToMod), .mem(mem));
  // free running system clock
  always #5 clk_sys = ~clk_sys;
  // count cold entries and restore copies as they begin
  always @(posedge clk_sys) begin
    if (clearData === 1'b1) nCold <= nCold + 1;
    if (copyToRam === 1'b1 && cpPrev !== 1'b1) nCopy <= nCopy + 1;
    cpPrev <= copyToRam;
  end
  task automatic end_sim();
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one event bit high for a single cycle
  task automatic pulse(input int b);
    tk(1);
    evt[b] <= 1'b1;
    tk(1);
    evt[b] <= 1'b0;
  endtask
  // one Avalon-MM access held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    tk(1);
    avReq <= '{read: !wr, write: wr, address: a, writedata: d};
    do begin
      tk(1);
    end while (waitrequest !== 1'b0);
    q = readdata;
    avReq.read <= 1'b0;
    avReq.write <= 1'b0;
  endtask
  // bounded wait for a state code; starts may need a copy first
  task automatic waitc(input logic [1:0] c);
    int n = 0;
    tk(4);
    while (stateCode !== c && n < 80) begin
      tk(1);
      n++;
    end
    tk(1); // let the edge counters catch the last pulse
  endtask
  // expected code in bits 1:0, cold flag in bit 2
  function automatic int model(int cur, int sel, int pow);
    if (sel == 1) return (cur == 0 && pow) ? 0 : 1;
    return (sel == 3 && !(cur == 2 && !pow)) ? 6 : 2;
  endfunction
  // reach not ready by a fault, then ready or run as asked
  task automatic goto(input int s);
    tk(1);
    evt[HWE] <= 1'b1;
    modeSel <= 2'h1;
    tk(1);
    evt[HWE] <= 1'b0;
    if (s > 0) pulse(RST);
    if (s > 1) modeSel <= 2'h2;
    if (s > 1) pulse(RST);
    waitc(s[1:0]);
  endtask
  initial begin
    #800000;
    error_cnt++;
    end_sim();
  end
  initial begin
    tk(5);
    rstn <= 1'b1;
    chk("stateCode", 0, stateCode);
    chk("dsw", 0, dswWord);
    bus(0, 4'h4, 0);
    chk("cfg", 0, q);
    r = $random(seed);
    bus(1, 4'h4, r);
    bus(0, 4'h4, 0);
    chk("cfg", r & 7, q);
    bus(1, 4'h4, 0);
    bus(0, 4'h1, 0);
    chk("unmapped", 0, q);
    for (int s = 0; s < 3; s++)
      for (int sel = 1; sel < 4; sel++)
        for (int p = 0; p < 2; p++) begin
          goto(s);
          e = model(s, sel, p);
          c0 = nCold;
          p0 = nCopy;
          r = $random(seed);
          lat <= r[3:0] & 4'h7;
          mm <= r[4] && e[1:0] == 2 && !(s == 2 && !p);
          modeSel <= sel[1:0];
          tk(1);
          mm <= 1'b0;
          pulse(p ? POW : RST);
          if (s == 2 && p) pulse(CYC);
          waitc(e[1:0]);
          tk(2);
          chk("stateCode", e & 3, stateCode);
          chk("cold", c0 + e[2], nCold);
          if (r[4] && e[1:0] == 2 && !(s == 2 && !p))
            chk("copy", p0 + 1, nCopy);
          if (sel == 1 && !p && s != 2) chk("dsw", 0, dswWord[0]);
          bus(0, 4'h8, 0);
          chk("status", e & 3, q[1:0]);
        end
    for (int f = 5; f < 8; f++) begin
      goto(2);
      evt[RST] <= 1'b1;
      evt[f] <= ~evt[f];
      tk(1);
      evt[RST] <= 1'b0;
      evt[f] <= ~evt[f];
      tk(1);
      chk("stateCode", 0, stateCode);
      chk("dsw", 1, dswWord[7-f]);
    end
    goto(2);
    evt[TAB] <= 1'b1;
    tk(2);
    chk("stateCode", 1, stateCode);
    chk("dsw", 1, dswWord[3]);
    evt[TAB] <= 1'b0;
    pulse(RST);
    waitc(2);
    pulse(RST);
    tk(3);
    chk("stateCode", 2, stateCode);
    chk("dsw", 0, dswWord[3]);
    bus(1, 4'h4, 1);
    evt[SLV] <= 1'b1;
    evt[MH] <= 1'b1;
    tk(2);
    chk("stateCode", 1, stateCode);
    evt[SLV] <= 1'b0;
    evt[MH] <= 1'b0;
    pulse(XFR);
    tk(2);
    chk("copyToMod", 1, copyToMod);
    bus(0, 4'h8, 0);
    chk("needCold", 1, q[2]);
    bus(1, 4'h0, 2);
    waitc(1);
    tk(6);
    chk("stateCode", 1, stateCode);
    c0 = nCold;
    bus(1, 4'h0, 4);
    waitc(2);
    chk("cold", c0 + 1, nCold);
    chk("exec", 1, execEnable);
    bus(1, 4'h0, 4);
    tk(8);
    chk("cold", c0 + 1, nCold);
    bus(1, 4'h0, 1);
    waitc(1);
    chk("stateCode", 1, stateCode);
    bus(1, 4'h4, 4);
    goto(0);
    modeSel <= 2'h2;
    pulse(RST);
    waitc(2);
    chk("cold", c0 + 2, nCold);
    // booted program with start condition halt: warm start ends not ready
    bus(1, 4'h4, 2);
    pulse(0);
    bus(1, 4'h0, 1);
    waitc(1);
    bus(1, 4'h0, 2);
    waitc(0);
    chk("stateCode", 0, stateCode);
    // a reset press while the clock enable is low must be lost
    clkEn <= 1'b0;
    modeSel <= 2'h1;
    pulse(RST);
    clkEn <= 1'b1;
    tk(3);
    chk("frozen", 0, stateCode);
    end_sim();
  end
endmodule
`default_nettype wire
